// >>> dv/oled_host_model.sv
// Purpose: Host side of the serial display link.
// Assumes: Serial clock idles low and runs only inside frames.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module oled_host_model (
  // Serial link pins.
  output logic sclk_o,
  output logic cs_n_o,
  output logic sd_o,
  output logic dc_o
);
  // ==========================================================================
  // Frame sender: n bits of a byte, then release.
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sd_o   = 1'b0;
    dc_o   = 1'b0;
  end
  task automatic send(input logic d, input logic [7:0] b, input int n);
    #7 cs_n_o = 1'b0;
    dc_o = d;
    for (int i = 7; i > 7 - n; i--)
    begin
      sd_o = b[i];
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    sd_o = ~sd_o;
    dc_o = ~dc_o;
  endtask : send
endmodule : oled_host_model
`default_nettype wire

// >>> dv/oled_serial_port_bench.sv
// Purpose: Self-checking bench for the serial display port.
// Assumes: Host model drives the link, bench drives the bus.
// Notes:   A byte settles six clocks after its frame.
`timescale 1ns/1ps
`default_nettype none
module oled_serial_port_bench;
  import oled_port_pkg::*;
  // ==========================================================================
  // Signals, instances and tasks.
  logic       clk_i = 0, rst_i = 1, pin_n = 0, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  wire logic  sclk, cs_n, sd, dc;
  logic       ack_o;
  disp_cfg_t  cfg_o;
  ram_write_t ram_o;
  int         errors = 0, checks_done = 0, cycles = 0;
  localparam disp_cfg_t RST_C = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CONTRAST_RST, START_LINE_RST,
                                  MUX_RST};
  localparam disp_cfg_t SET_C = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 6'h05, 6'h1f};
  localparam disp_cfg_t INV_C = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, CONTRAST_RST, START_LINE_RST,
                                  MUX_RST};
  logic [7:0] cmds [10] = '{8'haf, 8'h81, 8'h00, 8'ha1, 8'hc8, 8'ha5, 8'ha7, 8'h45, 8'ha8,
                            8'h1f};
  oled_host_model oled_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .sd_o(sd), .dc_o(dc));
  oled_serial_port oled_serial_port_i (.clk_i(clk_i), .rst_i(rst_i),
    .serial_clk_i(sclk), .chip_select_n_i(cs_n), .serial_data_i(sd),
    .data_command_select_i(dc), .module_reset_low_i(pin_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cfg_o(cfg_o), .ram_o(ram_o));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask : settle
  task automatic give_verdict;
    $display("Counts: %0d checks, %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Tests.
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    pin_n <= 1'b1;
    settle();
    chk(32'(cfg_o), 32'(RST_C));
    wb(0, STATUS_OFS, 0);
    chk(q, 32'h0);
    wb(0, CONFIG_OFS, 0);
    chk(q, 32'h003f007f);
    $display("reset values done");
    oled_host_model_i.send(0, CMD_DISP_OFF, 8);
    oled_host_model_i.send(0, 8'h3c, 4);
    foreach (cmds[i]) oled_host_model_i.send(0, cmds[i], 8);
    oled_host_model_i.send(1, 8'h5a, 8);
    settle();
    chk(32'(cfg_o), 32'(SET_C));
    wb(0, LAST_OFS, 0);
    chk(q, 32'h0000015a);
    wb(0, STATUS_OFS, 0);
    chk(q, 32'h0000011f);
    chk(32'(ram_o), 32'h0000015a);
    $display("command stream done");
    wb(1, CTRL_OFS, 32'h2);
    oled_host_model_i.send(0, CMD_DISP_OFF, 8);
    settle();
    chk(32'(cfg_o), 32'(SET_C));
    wb(1, CTRL_OFS, 32'h0);
    wb(1, CONFIG_OFS, 32'h0);
    wb(0, CONFIG_OFS, 0);
    chk(q, 32'h001f0500);
    wb(1, CTRL_OFS, 32'h1);
    chk(32'(cfg_o), 32'(RST_C));
    wb(1, CTRL_OFS, 32'h0);
    wb(0, 8'h40, 0);
    chk(q, 32'h0);
    $display("bus access done");
    oled_host_model_i.send(0, 8'hff, 4);
    @(posedge clk_i);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(cfg_o), 32'(RST_C));
    pin_n <= 1'b1;
    settle();
    wb(0, STATUS_OFS, 0);
    chk(q, 32'h0);
    oled_host_model_i.send(0, CMD_INVERSE, 8);
    settle();
    chk(32'(cfg_o), 32'(INV_C));
    $display("pin reset done");
    give_verdict();
  end
endmodule : oled_serial_port_bench
`default_nettype wire

// >>> dv/oled_serial_port_sva.sv
// Purpose: Assertions on the serial display port.
// Assumes: Bound to every instance of the port.
// Notes:   One clock domain, reset by rst_i.
`timescale 1ns/1ps
`default_nettype none
module oled_serial_port_sva
  import oled_port_pkg::*;
(
  // Clock, reset and reset pin.
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       module_reset_low_i,
  // Bus and outputs.
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire disp_cfg_t  cfg_o,
  input wire ram_write_t ram_o
);
  // ==========================================================================
  // Properties.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pin_low; !module_reset_low_i [*4]; endsequence
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("Request left without ack.");
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("Ack longer than one cycle.");
  property p_off; s_pin_low |-> !cfg_o.display_on && !cfg_o.entire_on; endproperty
  a_off: assert property (p_off)
    else $error("Display not off in reset.");
  property p_map; s_pin_low |-> !cfg_o.seg_remap && cfg_o.mux_ratio == MUX_RST; endproperty
  a_map: assert property (p_map)
    else $error("Mapping not normal in reset.");
  property p_start; s_pin_low |-> cfg_o.start_line == START_LINE_RST; endproperty
  a_start: assert property (p_start)
    else $error("Start line not zero in reset.");
  property p_contrast; s_pin_low |-> cfg_o.contrast == CONTRAST_RST; endproperty
  a_contrast: assert property (p_contrast)
    else $error("Contrast wrong in reset.");
  property p_scan; s_pin_low |-> !cfg_o.scan_reverse && !cfg_o.inverse; endproperty
  a_scan: assert property (p_scan)
    else $error("Scan or inverse set in reset.");
  property p_we; ram_o.we |=> !ram_o.we; endproperty
  a_we: assert property (p_we)
    else $error("Data write longer than one cycle.");
endmodule : oled_serial_port_sva
bind oled_serial_port oled_serial_port_sva oled_serial_port_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .module_reset_low_i(module_reset_low_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .cfg_o(cfg_o), .ram_o(ram_o));
`default_nettype wire

// >>> logic/oled_port_pkg.sv
// Purpose: Shared constants and types for the serial display controller port.
// Assumes: Wishbone classic slave with 32-bit data and byte addresses.
// Notes:   Reset values are the documented power-on state of the controller.
package oled_port_pkg;

  // ==========================================================================
  // Register map.
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CONFIG_OFS = 8'h08;
  localparam logic [7:0] LAST_OFS   = 8'h0c;

  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_PORT_OFF_BIT   = 1;

  // ==========================================================================
  // Reset values and counts.
  // ==========================================================================
  localparam logic [7:0] CONTRAST_RST   = 8'h7f;
  localparam logic [5:0] START_LINE_RST = 6'h00;
  localparam logic [6:0] COLUMN_RST     = 7'h00;
  localparam logic [2:0] PAGE_RST       = 3'h0;
  localparam logic [5:0] MUX_RST        = 6'h3f;
  localparam logic [6:0] COLUMN_LAST    = 7'h7f;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam int         SYNC_STAGES    = 2;

  // ==========================================================================
  // Command codes.
  // ==========================================================================
  localparam logic [7:0] CMD_DISP_OFF   = 8'hae;
  localparam logic [7:0] CMD_DISP_ON    = 8'haf;
  localparam logic [7:0] CMD_CONTRAST   = 8'h81;
  localparam logic [7:0] CMD_SEG_NORM   = 8'ha0;
  localparam logic [7:0] CMD_SEG_REMAP  = 8'ha1;
  localparam logic [7:0] CMD_RAM_SHOW   = 8'ha4;
  localparam logic [7:0] CMD_ALL_ON     = 8'ha5;
  localparam logic [7:0] CMD_NORMAL     = 8'ha6;
  localparam logic [7:0] CMD_INVERSE    = 8'ha7;
  localparam logic [7:0] CMD_MUX        = 8'ha8;
  localparam logic [7:0] CMD_SCAN_NORM  = 8'hc0;
  localparam logic [7:0] CMD_SCAN_REV   = 8'hc8;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [1:0] {
    ARG_NONE,
    ARG_CONTRAST,
    ARG_MUX,
    ARG_SKIP
  } arg_state_t;

  typedef struct packed {
    logic       display_on;
    logic       entire_on;
    logic       inverse;
    logic       seg_remap;
    logic       scan_reverse;
    logic [7:0] contrast;
    logic [5:0] start_line;
    logic [5:0] mux_ratio;
  } disp_cfg_t;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } rx_byte_t;

  typedef struct packed {
    logic       we;
    logic [2:0] page;
    logic [6:0] column;
    logic [7:0] data;
  } ram_write_t;

endpackage : oled_port_pkg

// >>> logic/oled_serial_port.sv
// Purpose: Serial command and data receiver of a 128x64 display controller.
// Assumes: Link flops run on the host serial clock, which stops between frames.
// Notes:   Registers reached over classic Wishbone; one data word per register.
//
// Behaviour
// RULE1: Host orders supplies before enabling panel voltage.
// RULE2: Host waits 100ms before display-on command.
// RULE3: Host turns off display, supplies, then waits.
// RULE4: Host keeps logic supply while panel powered.
// RULE5: Reset gives display off, normal RAM display.
// RULE6: Reset selects 128x64 with normal address mapping.
// RULE7: Reset clears serial input shift register.
// RULE8: Reset zeroes start line and column counter.
// RULE9: Reset loads contrast with 7Fh.
// RULE10: Reset selects normal common scan direction.
// RULE11: Host resets display after noise corruption.
// RULE12: Chip select frames bytes; select marks data.
// RULE13: Eight bits, MSB first, sampled on rise.
`timescale 1ns/1ps
`default_nettype none

module oled_serial_port
  import oled_port_pkg::*;
(
  // System clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial link pins.
  input  wire logic        serial_clk_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_data_i,
  input  wire logic        data_command_select_i,
  input  wire logic        module_reset_low_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Panel state and display memory write port.
  output disp_cfg_t        cfg_o,
  output ram_write_t       ram_o
);

  // ==========================================================================
  // Link domain: shift register cleared by frame end or reset pin.
  // ==========================================================================
  logic       link_clear;
  logic [6:0] shift_r;
  logic [2:0] bit_cnt_r;
  rx_byte_t   hold_r;
  logic       rx_toggle_r;
  logic       port_off_sync_r;
  logic       port_off_link_r;
  logic       ctrl_soft_reset_r;
  logic       ctrl_port_off_r;

  assign link_clear = chip_select_n_i | ~module_reset_low_i; // RULE12

  always_ff @(posedge serial_clk_i or posedge link_clear)
  begin
    if (link_clear)
    begin
      shift_r   <= 7'h00; // RULE7
      bit_cnt_r <= 3'h0;  // RULE7
    end
    else
    begin
      shift_r   <= {shift_r[5:0], serial_data_i}; // RULE13
      bit_cnt_r <= bit_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge serial_clk_i or negedge module_reset_low_i)
  begin
    if (!module_reset_low_i)
    begin
      hold_r      <= '0;
      rx_toggle_r <= 1'b0;
    end
    else if (!chip_select_n_i && bit_cnt_r == BIT_LAST && !port_off_link_r)
    begin
      hold_r      <= '{is_data: data_command_select_i,
                       value: {shift_r, serial_data_i}}; // RULE12 RULE13
      rx_toggle_r <= ~rx_toggle_r;
    end
  end

  // Port-off control level crosses into the link domain.
  always_ff @(posedge serial_clk_i or negedge module_reset_low_i)
  begin
    if (!module_reset_low_i)
    begin
      port_off_sync_r <= 1'b0;
      port_off_link_r <= 1'b0;
    end
    else
    begin
      port_off_sync_r <= ctrl_port_off_r;
      port_off_link_r <= port_off_sync_r;
    end
  end

  // ==========================================================================
  // System domain: reset pin and byte event synchronisers.
  // ==========================================================================
  logic [SYNC_STAGES-1:0] pin_sync_r;
  logic                   core_rst;
  logic [SYNC_STAGES-1:0] tog_sync_r;
  logic                   tog_seen_r;
  logic                   byte_evt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pin_sync_r <= '0;
    else
      pin_sync_r <= {pin_sync_r[0], module_reset_low_i};
  end

  assign core_rst = rst_i | ~pin_sync_r[SYNC_STAGES-1] | ctrl_soft_reset_r;

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      tog_sync_r <= '0;
      tog_seen_r <= 1'b0;
    end
    else
    begin
      tog_sync_r <= {tog_sync_r[0], rx_toggle_r};
      tog_seen_r <= tog_sync_r[SYNC_STAGES-1];
    end
  end

  assign byte_evt = tog_sync_r[SYNC_STAGES-1] ^ tog_seen_r;

  // ==========================================================================
  // Command decoder and display state.
  // ==========================================================================
  disp_cfg_t  cfg_r;
  disp_cfg_t  cfg_nxt;
  arg_state_t arg_r;
  arg_state_t arg_nxt;
  logic [6:0] column_r;
  logic [6:0] column_nxt;
  logic [2:0] page_r;
  logic [2:0] page_nxt;
  rx_byte_t   last_r;
  ram_write_t ram_r;
  logic [7:0] b;
  logic       is_cmd;
  logic       is_data;

  assign b       = hold_r.value;
  assign is_cmd  = byte_evt & ~hold_r.is_data; // RULE12
  assign is_data = byte_evt &  hold_r.is_data; // RULE12

  always_comb
  begin
    cfg_nxt    = cfg_r;
    arg_nxt    = arg_r;
    column_nxt = column_r;
    page_nxt   = page_r;
    if (is_data)
      column_nxt = (column_r == COLUMN_LAST) ? COLUMN_RST : column_r + 7'h01;
    else if (is_cmd)
    begin
      case (arg_r)
        ARG_CONTRAST:
        begin
          cfg_nxt.contrast = b;
          arg_nxt          = ARG_NONE;
        end
        ARG_MUX:
        begin
          cfg_nxt.mux_ratio = b[5:0];
          arg_nxt           = ARG_NONE;
        end
        ARG_SKIP:
          arg_nxt = ARG_NONE;
        default:
        begin
          if (b == CMD_DISP_OFF)
            cfg_nxt.display_on = 1'b0;
          else if (b == CMD_DISP_ON)
            cfg_nxt.display_on = 1'b1;
          else if (b == CMD_CONTRAST)
            arg_nxt = ARG_CONTRAST;
          else if (b == CMD_MUX)
            arg_nxt = ARG_MUX;
          else if (b == CMD_SEG_NORM || b == CMD_SEG_REMAP)
            cfg_nxt.seg_remap = b[0];
          else if (b == CMD_RAM_SHOW || b == CMD_ALL_ON)
            cfg_nxt.entire_on = b[0];
          else if (b == CMD_NORMAL || b == CMD_INVERSE)
            cfg_nxt.inverse = b[0];
          else if (b == CMD_SCAN_NORM || b == CMD_SCAN_REV)
            cfg_nxt.scan_reverse = b[3];
          else if (b[7:4] == 4'h0)
            column_nxt = {column_r[6:4], b[3:0]};
          else if (b[7:4] == 4'h1)
            column_nxt = {b[2:0], column_r[3:0]};
          else if (b[7:6] == 2'b01)
            cfg_nxt.start_line = b[5:0];
          else if (b[7:3] == 5'b10110)
            page_nxt = b[2:0];
          else if (b == 8'h20 || b == 8'h8d || b == 8'hd3 || b == 8'hd5 ||
                   b == 8'hd9 || b == 8'hda || b == 8'hdb)
            arg_nxt = ARG_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      cfg_r.display_on   <= 1'b0;           // RULE5
      cfg_r.entire_on    <= 1'b0;           // RULE5
      cfg_r.inverse      <= 1'b0;           // RULE5
      cfg_r.seg_remap    <= 1'b0;           // RULE6
      cfg_r.mux_ratio    <= MUX_RST;        // RULE6
      cfg_r.scan_reverse <= 1'b0;           // RULE10
      cfg_r.contrast     <= CONTRAST_RST;   // RULE9
      cfg_r.start_line   <= START_LINE_RST; // RULE8
      column_r           <= COLUMN_RST;     // RULE8
      page_r             <= PAGE_RST;
      arg_r              <= ARG_NONE;
    end
    else
    begin
      cfg_r    <= cfg_nxt;
      column_r <= column_nxt;
      page_r   <= page_nxt;
      arg_r    <= arg_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (core_rst)
    begin
      ram_r  <= '0;
      last_r <= '0;
    end
    else
    begin
      ram_r <= '{we: is_data, page: page_r, column: column_r, data: b};
      if (byte_evt)
        last_r <= hold_r;
    end
  end

  assign cfg_o = cfg_r;
  assign ram_o = ram_r;

  // ==========================================================================
  // Wishbone slave: answers every access one cycle after it is presented.
  // ==========================================================================
  logic        ack_r;
  logic        bus_req;
  logic        wr_ctrl;
  logic [31:0] rd_mux;
  logic [31:0] rd_r;

  assign bus_req = cyc_i & stb_i & ~ack_r;
  assign wr_ctrl = bus_req & we_i & sel_i[0] & (adr_i == CTRL_OFS);

  always_comb
  begin
    if (adr_i == CTRL_OFS)
      rd_mux = {30'h0, ctrl_port_off_r, ctrl_soft_reset_r};
    else if (adr_i == STATUS_OFS)
      rd_mux = {12'h0, arg_r, page_r, column_r, 3'h0,
                cfg_r.scan_reverse, cfg_r.seg_remap, cfg_r.inverse,
                cfg_r.entire_on, cfg_r.display_on};
    else if (adr_i == CONFIG_OFS)
      rd_mux = {10'h0, cfg_r.mux_ratio, 2'h0, cfg_r.start_line, cfg_r.contrast};
    else if (adr_i == LAST_OFS)
      rd_mux = {23'h0, last_r.is_data, last_r.value};
    else
      rd_mux = 32'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r             <= 1'b0;
      rd_r              <= 32'h0;
      ctrl_soft_reset_r <= 1'b0;
      ctrl_port_off_r   <= 1'b0;
    end
    else
    begin
      ack_r <= bus_req;
      if (bus_req && !we_i)
        rd_r <= rd_mux;
      if (wr_ctrl)
      begin
        ctrl_soft_reset_r <= dat_i[CTRL_SOFT_RESET_BIT]; // RULE11
        ctrl_port_off_r   <= dat_i[CTRL_PORT_OFF_BIT];
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rd_r;

endmodule : oled_serial_port

`default_nettype wire
